// ---- mb_defines.svh ----
`ifndef MB_DEFINES_SVH
`define MB_DEFINES_SVH

// zero-based coil positions in the coil image
`define MB_COIL_CTRL       7'h00
`define MB_COIL_REF        7'h10
`define MB_COIL_STAT       7'h20
`define MB_COIL_ACT        7'h30
`define MB_COIL_PWC        7'h40
`define MB_NUM_COILS       16'h0041
`define MB_COIL_WR_LAST    17'h0001F

// control word field positions
`define MB_CTL_PRESET      0
`define MB_CTL_DCBRAKE_N   2
`define MB_CTL_COAST_N     3
`define MB_CTL_QSTOP_N     4
`define MB_CTL_FREEZE_N    5
`define MB_CTL_START       6
`define MB_CTL_RESET       7
`define MB_CTL_JOG         8
`define MB_CTL_RAMP2       9
`define MB_CTL_DVALID      10
`define MB_CTL_RELAY1      11
`define MB_CTL_RELAY2      12
`define MB_CTL_SETUP       13
`define MB_CTL_REVERSE     15

// status coils 37-39 and 45 are unused and read zero
`define MB_STAT_USED_MASK  16'hEF8F

// holding register numbers, bus address is number minus one
`define MB_REG_LAST_ERR    16'h0007
`define MB_REG_PAR_INDEX   16'h0009
`define MB_REG_PAR_FIRST   16'h0064
`define MB_REG_PAR_LAST    16'hC34F
`define MB_REG_CTRL_PRINT  20'h7A120
`define MB_REG_CTRL        16'hC350
`define MB_REG_REF         16'hC35A
`define MB_REG_STATUS      16'hC418
`define MB_REG_ACTUAL      16'hC422
`define MB_HR_ADDR(n)      ((n) - 16'h0001)
`define MB_MAX_REGS        16'h007D

// reset values
`define MB_CTRL_RESET      16'h0000
`define MB_REF_RESET       16'h0000
`define MB_INDEX_RESET     16'h0000

// coil force values
`define MB_COIL_ON         16'hFF00
`define MB_COIL_OFF        16'h0000

// exception handling
`define MB_EXC_FLAG        8'h80
`define MB_EXC_NONE        8'h00
`define MB_EXC_BAD_ADDR    8'h40
`define MB_EXC_BAD_DATA    8'h42
`define MB_EXC_BAD_FUNC    8'h43
`define MB_ID_RUN          16'h00FF

// diagnostic counter slots
`define MB_NUM_CNT         5
`define MB_CNT_BUS         0
`define MB_CNT_COMM_ERR    1
`define MB_CNT_EXC         2
`define MB_CNT_SLAVE       3
`define MB_CNT_EVENT       4

`endif

// ---- mb_pkg.sv ----
package mb_pkg;

	typedef enum logic [7:0] {
		MB_FN_RD_COILS = 8'h01,
		MB_FN_RD_REGS  = 8'h03,
		MB_FN_WR_COIL  = 8'h05,
		MB_FN_WR_REG   = 8'h06,
		MB_FN_DIAG     = 8'h08,
		MB_FN_EVENT    = 8'h0B,
		MB_FN_WR_COILS = 8'h0F,
		MB_FN_WR_REGS  = 8'h10,
		MB_FN_SLAVE_ID = 8'h11
	} mb_func_t;

	typedef enum logic [15:0] {
		MB_SUB_RESTART   = 16'h0001,
		MB_SUB_DIAG_REG  = 16'h0002,
		MB_SUB_CLEAR     = 16'h000A,
		MB_SUB_BUS_MSG   = 16'h000B,
		MB_SUB_COMM_ERR  = 16'h000C,
		MB_SUB_EXC_ERR   = 16'h000D,
		MB_SUB_SLAVE_MSG = 16'h000E
	} mb_sub_t;

	typedef enum {
		ST_IDLE,
		ST_CHECK,
		ST_RD_COIL,
		ST_RD_REG,
		ST_PAR_WAIT,
		ST_WR_COIL,
		ST_WR_REG,
		ST_ECHO,
		ST_FINISH
	} mb_state_t;

endpackage : mb_pkg

// ---- mb_diag_counters.sv ----
`timescale 1ns/1ns
`default_nettype none
module mb_diag_counters #(
	parameter int N = 5,
	parameter int W = 16
) (
	input  wire logic           clk_in,
	input  wire logic           rst_in,
	input  wire logic [N-1:0]   inc_in,
	input  wire logic           clr_in,
	output logic      [N*W-1:0] count_out
);
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_cnt
			// an increment in the clearing cycle is kept
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					count_out[i*W +: W] <= '0;
				end else if (clr_in) begin
					count_out[i*W +: W] <= W'(inc_in[i]);
				end else if (inc_in[i]) begin
					count_out[i*W +: W] <= count_out[i*W +: W] + W'(1);
				end
			end
		end
	endgenerate
endmodule : mb_diag_counters
`default_nettype wire

// ---- mb_data_map.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "mb_defines.svh"
module mb_data_map #(
	parameter logic [15:0] SLAVE_ID = 16'h005A // arbitrary value
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        req_valid_in,
	input  wire logic        req_bcast_in,
	input  wire logic [7:0]  req_func_in,
	input  wire logic [15:0] req_addr_in,
	input  wire logic [15:0] req_qty_in,
	input  wire logic        wd_valid_in,
	input  wire logic [15:0] wd_data_in,
	input  wire logic        bus_msg_in,
	input  wire logic        comm_err_in,
	input  wire logic [15:0] status_word_in,
	input  wire logic [15:0] actual_value_in,
	input  wire logic        par_ack_in,
	input  wire logic        par_fail_in,
	input  wire logic [15:0] par_rdata_in,
	input  wire logic [7:0]  par_errcode_in,
	output logic             busy_out,
	output logic             wd_ready_out,
	output logic             rsp_item_valid_out,
	output logic      [15:0] rsp_item_out,
	output logic             rsp_done_out,
	output logic      [7:0]  rsp_func_out,
	output logic      [7:0]  rsp_exc_out,
	output logic             comm_restart_out,
	output logic             par_req_out,
	output logic             par_we_out,
	output logic      [15:0] par_regnum_out,
	output logic      [15:0] par_wdata_out,
	output logic      [15:0] par_index_out,
	output logic             par_eeprom_out,
	output logic      [1:0]  preset_ref_out,
	output logic             dc_brake_n_out,
	output logic             coast_n_out,
	output logic             quick_stop_n_out,
	output logic             freeze_n_out,
	output logic             start_out,
	output logic             fault_reset_out,
	output logic             jog_out,
	output logic             ramp2_out,
	output logic             data_valid_out,
	output logic             relay1_out,
	output logic             relay2_out,
	output logic      [1:0]  setup_sel_out,
	output logic             reverse_out,
	output logic      [15:0] speed_ref_out
);
	import mb_pkg::*;

	mb_state_t                 st_q;
	logic      [7:0]           func_q;
	logic      [15:0]          addr_q;
	logic      [15:0]          qty_q;
	logic                      bcast_q;
	logic      [15:0]          pos_q;
	logic      [15:0]          left_q;
	logic      [7:0]           exc_q;
	logic                      echo_sel_q;
	logic      [15:0]          ctl_q;
	logic      [15:0]          ref_q;
	logic                      pwc_q;
	logic      [15:0]          idx_q;
	logic      [15:0]          last_err_q;
	logic      [15:0]          diag_q;
	logic      [7:0]           chk_exc;
	logic      [7:0]           coil_byte;
	logic      [64:0]          coil_img;
	logic      [64:0]          coil_sh;
	logic                      map_we;
	logic      [32:0]          map_nxt;
	logic                      sw_en;
	logic      [15:0]          sw_a;
	logic      [15:0]          sw_v;
	logic                      wd_take;
	logic                      cnt_clr;
	logic      [4:0]           cnt_inc;
	logic      [16*5-1:0]      cnt_all;
	logic      [16:0]          end17;

	function automatic logic is_par(input logic [15:0] a);
		is_par = (a >= `MB_HR_ADDR(`MB_REG_PAR_FIRST)) && (a <= `MB_HR_ADDR(`MB_REG_PAR_LAST));
	endfunction : is_par

	function automatic logic wr_ok(input logic [15:0] a);
		wr_ok = is_par(a) || (a == `MB_HR_ADDR(`MB_REG_PAR_INDEX)) ||
			(a == `MB_HR_ADDR(`MB_REG_CTRL)) || (a == `MB_HR_ADDR(`MB_REG_REF));
	endfunction : wr_ok

	function automatic logic rd_ok(input logic [15:0] a);
		rd_ok = wr_ok(a) || (a == `MB_HR_ADDR(`MB_REG_LAST_ERR)) ||
			(a == `MB_HR_ADDR(`MB_REG_STATUS)) || (a == `MB_HR_ADDR(`MB_REG_ACTUAL));
	endfunction : rd_ok

	function automatic logic [15:0] hr_value(input logic [15:0] a);
		hr_value = 16'h0000;
		if (a == `MB_HR_ADDR(`MB_REG_LAST_ERR)) hr_value = last_err_q;
		if (a == `MB_HR_ADDR(`MB_REG_PAR_INDEX)) hr_value = idx_q;
		if (a == `MB_HR_ADDR(`MB_REG_CTRL)) hr_value = ctl_q;
		if (a == `MB_HR_ADDR(`MB_REG_REF)) hr_value = ref_q;
		if (a == `MB_HR_ADDR(`MB_REG_STATUS)) hr_value = status_word_in & `MB_STAT_USED_MASK;
		if (a == `MB_HR_ADDR(`MB_REG_ACTUAL)) hr_value = actual_value_in;
	endfunction : hr_value

	assign end17   = {1'b0, addr_q} + {1'b0, qty_q} - 17'h00001;
	assign wd_take = wd_valid_in && wd_ready_out;

	// control coils, reference coils, status coils, actual value coils, storage coil
	assign coil_img = {pwc_q, actual_value_in, status_word_in & `MB_STAT_USED_MASK, ref_q, ctl_q};
	assign coil_sh  = coil_img >> pos_q[6:0];

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			coil_byte[i] = (16'(i) < left_q) ? coil_sh[i] : 1'b0;
		end
	end

	always_comb begin
		chk_exc = `MB_EXC_NONE;
		case (func_q)
			MB_FN_RD_COILS: begin
				if (qty_q == 16'h0000 || qty_q > `MB_NUM_COILS) chk_exc = `MB_EXC_BAD_DATA;
				else if (end17 >= {1'b0, `MB_NUM_COILS}) chk_exc = `MB_EXC_BAD_ADDR;
			end
			MB_FN_WR_COIL: begin
				if (addr_q > 16'(`MB_COIL_WR_LAST) && addr_q != {9'h000, `MB_COIL_PWC})
					chk_exc = `MB_EXC_BAD_ADDR;
				else if (qty_q != `MB_COIL_OFF && qty_q != `MB_COIL_ON) chk_exc = `MB_EXC_BAD_DATA;
			end
			MB_FN_WR_COILS: begin
				if (qty_q == 16'h0000 || qty_q > `MB_NUM_COILS) chk_exc = `MB_EXC_BAD_DATA;
				else if (!(end17 <= `MB_COIL_WR_LAST ||
					(addr_q == {9'h000, `MB_COIL_PWC} && qty_q == 16'h0001)))
					chk_exc = `MB_EXC_BAD_ADDR;
			end
			MB_FN_RD_REGS, MB_FN_WR_REGS: begin
				if (qty_q == 16'h0000 || qty_q > `MB_MAX_REGS) chk_exc = `MB_EXC_BAD_DATA;
				else if (qty_q == 16'h0001) begin
					if (func_q == MB_FN_RD_REGS ? !rd_ok(addr_q) : !wr_ok(addr_q))
						chk_exc = `MB_EXC_BAD_ADDR;
				end else if (!(is_par(addr_q) && end17 <= {1'b0, `MB_HR_ADDR(`MB_REG_PAR_LAST)}))
					chk_exc = `MB_EXC_BAD_ADDR;
			end
			MB_FN_WR_REG: begin
				if (!wr_ok(addr_q)) chk_exc = `MB_EXC_BAD_ADDR;
			end
			MB_FN_DIAG: begin
				if (!(addr_q inside {MB_SUB_RESTART, MB_SUB_DIAG_REG, MB_SUB_CLEAR, MB_SUB_BUS_MSG,
					MB_SUB_COMM_ERR, MB_SUB_EXC_ERR, MB_SUB_SLAVE_MSG}))
					chk_exc = `MB_EXC_BAD_DATA;
			end
			MB_FN_EVENT, MB_FN_SLAVE_ID: chk_exc = `MB_EXC_NONE;
			default: chk_exc = `MB_EXC_BAD_FUNC;
		endcase
	end

	// coil and special-register write strobes
	always_comb begin
		map_we  = 1'b0;
		map_nxt = {pwc_q, ref_q, ctl_q};
		sw_en   = 1'b0;
		sw_a    = pos_q;
		sw_v    = wd_data_in;
		case (st_q)
			ST_CHECK: begin
				if (chk_exc == `MB_EXC_NONE && func_q == MB_FN_WR_COIL) begin
					map_we = 1'b1;
					if (addr_q == {9'h000, `MB_COIL_PWC}) map_nxt[32] = (qty_q == `MB_COIL_ON);
					else map_nxt[addr_q[4:0]] = (qty_q == `MB_COIL_ON);
				end
				if (chk_exc == `MB_EXC_NONE && func_q == MB_FN_WR_REG && !is_par(addr_q)) begin
					sw_en = 1'b1;
					sw_a  = addr_q;
					sw_v  = qty_q;
				end
			end
			ST_WR_COIL: begin
				if (wd_take) begin
					map_we = 1'b1;
					for (int i = 0; i < 16; i++) begin
						if (16'(i) < left_q) begin
							if (pos_q + 16'(i) == {9'h000, `MB_COIL_PWC}) map_nxt[32] = wd_data_in[i];
							else if (pos_q + 16'(i) <= 16'(`MB_COIL_WR_LAST))
								map_nxt[5'(pos_q + 16'(i))] = wd_data_in[i];
						end
					end
				end
			end
			ST_WR_REG: sw_en = wd_take && !is_par(pos_q);
			default: sw_en = 1'b0;
		endcase
		if (sw_en && sw_a == `MB_HR_ADDR(`MB_REG_CTRL)) begin
			map_we        = 1'b1;
			map_nxt[15:0] = sw_v;
		end
		if (sw_en && sw_a == `MB_HR_ADDR(`MB_REG_REF)) begin
			map_we         = 1'b1;
			map_nxt[31:16] = sw_v;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctl_q <= `MB_CTRL_RESET;
			ref_q <= `MB_REF_RESET;
			pwc_q <= 1'b0;
		end else if (map_we) begin
			ctl_q <= map_nxt[15:0];
			ref_q <= map_nxt[31:16];
			pwc_q <= map_nxt[32];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			idx_q <= `MB_INDEX_RESET;
		end else if (sw_en && sw_a == `MB_HR_ADDR(`MB_REG_PAR_INDEX)) begin
			idx_q <= sw_v;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			last_err_q <= 16'h0000;
		end else if (st_q == ST_PAR_WAIT && par_ack_in && par_fail_in) begin
			last_err_q <= {8'h00, par_errcode_in};
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			diag_q <= 16'h0000;
		end else if (st_q == ST_FINISH && exc_q != `MB_EXC_NONE) begin
			diag_q <= {8'h00, exc_q};
		end else if (cnt_clr) begin
			diag_q <= 16'h0000;
		end
	end

	assign cnt_clr = st_q == ST_CHECK && chk_exc == `MB_EXC_NONE && func_q == MB_FN_DIAG &&
		(addr_q == MB_SUB_RESTART || addr_q == MB_SUB_CLEAR);
	assign cnt_inc[`MB_CNT_BUS]      = bus_msg_in;
	assign cnt_inc[`MB_CNT_COMM_ERR] = comm_err_in;
	assign cnt_inc[`MB_CNT_EXC]      = st_q == ST_FINISH && exc_q != `MB_EXC_NONE;
	assign cnt_inc[`MB_CNT_SLAVE]    = st_q == ST_IDLE && req_valid_in;
	assign cnt_inc[`MB_CNT_EVENT]    = st_q == ST_FINISH && exc_q == `MB_EXC_NONE;

	mb_diag_counters #(
		.N(`MB_NUM_CNT),
		.W(16)
	) u_counters (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.inc_in    (cnt_inc),
		.clr_in    (cnt_clr),
		.count_out (cnt_all)
	);

	// request sequencing
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= ST_IDLE;
			func_q <= 8'h00;
			addr_q <= 16'h0000;
			qty_q <= 16'h0000;
			bcast_q <= 1'b0;
			pos_q <= 16'h0000;
			left_q <= 16'h0000;
			exc_q <= `MB_EXC_NONE;
			echo_sel_q <= 1'b0;
			busy_out <= 1'b0;
			wd_ready_out <= 1'b0;
			rsp_item_valid_out <= 1'b0;
			rsp_item_out <= 16'h0000;
			rsp_done_out <= 1'b0;
			rsp_func_out <= 8'h00;
			rsp_exc_out <= `MB_EXC_NONE;
			comm_restart_out <= 1'b0;
			par_req_out <= 1'b0;
			par_we_out <= 1'b0;
			par_regnum_out <= 16'h0000;
			par_wdata_out <= 16'h0000;
		end else begin
			rsp_item_valid_out <= 1'b0;
			rsp_done_out <= 1'b0;
			comm_restart_out <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					if (req_valid_in) begin
						func_q <= req_func_in;
						addr_q <= req_addr_in;
						qty_q <= req_qty_in;
						bcast_q <= req_bcast_in;
						exc_q <= `MB_EXC_NONE;
						echo_sel_q <= 1'b0;
						busy_out <= 1'b1;
						st_q <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					pos_q <= addr_q;
					left_q <= qty_q;
					if (chk_exc != `MB_EXC_NONE) begin
						exc_q <= chk_exc;
						st_q <= ST_FINISH;
					end else begin
						case (func_q)
							MB_FN_RD_COILS: st_q <= ST_RD_COIL;
							MB_FN_RD_REGS: st_q <= ST_RD_REG;
							MB_FN_WR_COILS: begin
								wd_ready_out <= 1'b1;
								st_q <= ST_WR_COIL;
							end
							MB_FN_WR_REGS: begin
								wd_ready_out <= 1'b1;
								st_q <= ST_WR_REG;
							end
							MB_FN_WR_REG: begin
								if (is_par(addr_q)) begin
									par_req_out <= 1'b1;
									par_we_out <= 1'b1;
									par_regnum_out <= addr_q + 16'h0001;
									par_wdata_out <= qty_q;
									st_q <= ST_PAR_WAIT;
								end else begin
									st_q <= ST_ECHO;
								end
							end
							MB_FN_DIAG: begin
								case (addr_q)
									MB_SUB_RESTART: comm_restart_out <= 1'b1;
									MB_SUB_DIAG_REG: qty_q <= diag_q;
									MB_SUB_BUS_MSG: qty_q <= cnt_all[16*`MB_CNT_BUS +: 16];
									MB_SUB_COMM_ERR: qty_q <= cnt_all[16*`MB_CNT_COMM_ERR +: 16];
									MB_SUB_EXC_ERR: qty_q <= cnt_all[16*`MB_CNT_EXC +: 16];
									MB_SUB_SLAVE_MSG: qty_q <= cnt_all[16*`MB_CNT_SLAVE +: 16];
									default: qty_q <= qty_q;
								endcase
								st_q <= ST_ECHO;
							end
							MB_FN_EVENT: begin
								addr_q <= 16'h0000;
								qty_q <= cnt_all[16*`MB_CNT_EVENT +: 16];
								st_q <= ST_ECHO;
							end
							MB_FN_SLAVE_ID: begin
								addr_q <= SLAVE_ID;
								qty_q <= `MB_ID_RUN;
								st_q <= ST_ECHO;
							end
							default: st_q <= ST_ECHO;
						endcase
					end
				end
				ST_RD_COIL: begin
					rsp_item_valid_out <= !bcast_q;
					rsp_item_out <= {8'h00, coil_byte};
					pos_q <= pos_q + 16'h0008;
					left_q <= (left_q > 16'h0008) ? left_q - 16'h0008 : 16'h0000;
					if (left_q <= 16'h0008) st_q <= ST_FINISH;
				end
				ST_RD_REG: begin
					if (is_par(pos_q)) begin
						par_req_out <= 1'b1;
						par_we_out <= 1'b0;
						par_regnum_out <= pos_q + 16'h0001;
						st_q <= ST_PAR_WAIT;
					end else begin
						rsp_item_valid_out <= !bcast_q;
						rsp_item_out <= hr_value(pos_q);
						pos_q <= pos_q + 16'h0001;
						left_q <= left_q - 16'h0001;
						if (left_q == 16'h0001) st_q <= ST_FINISH;
					end
				end
				ST_PAR_WAIT: begin
					if (par_ack_in) begin
						par_req_out <= 1'b0;
						pos_q <= pos_q + 16'h0001;
						left_q <= left_q - 16'h0001;
						if (par_fail_in) begin
							exc_q <= par_errcode_in;
							st_q <= ST_FINISH;
						end else if (func_q == MB_FN_RD_REGS) begin
							rsp_item_valid_out <= !bcast_q;
							rsp_item_out <= par_rdata_in;
							st_q <= (left_q == 16'h0001) ? ST_FINISH : ST_RD_REG;
						end else if (func_q == MB_FN_WR_REGS && left_q != 16'h0001) begin
							wd_ready_out <= 1'b1;
							st_q <= ST_WR_REG;
						end else begin
							st_q <= ST_ECHO;
						end
					end
				end
				ST_WR_COIL: begin
					if (wd_take) begin
						pos_q <= pos_q + 16'h0010;
						left_q <= (left_q > 16'h0010) ? left_q - 16'h0010 : 16'h0000;
						if (left_q <= 16'h0010) begin
							wd_ready_out <= 1'b0;
							st_q <= ST_ECHO;
						end
					end
				end
				ST_WR_REG: begin
					if (wd_take) begin
						if (is_par(pos_q)) begin
							wd_ready_out <= 1'b0;
							par_req_out <= 1'b1;
							par_we_out <= 1'b1;
							par_regnum_out <= pos_q + 16'h0001;
							par_wdata_out <= wd_data_in;
							st_q <= ST_PAR_WAIT;
						end else begin
							pos_q <= pos_q + 16'h0001;
							left_q <= left_q - 16'h0001;
							if (left_q == 16'h0001) begin
								wd_ready_out <= 1'b0;
								st_q <= ST_ECHO;
							end
						end
					end
				end
				ST_ECHO: begin
					rsp_item_valid_out <= !bcast_q;
					rsp_item_out <= echo_sel_q ? qty_q : addr_q;
					echo_sel_q <= 1'b1;
					if (echo_sel_q) st_q <= ST_FINISH;
				end
				ST_FINISH: begin
					rsp_done_out <= !bcast_q;
					rsp_func_out <= (exc_q != `MB_EXC_NONE) ? (func_q | `MB_EXC_FLAG) : func_q;
					rsp_exc_out <= exc_q;
					busy_out <= 1'b0;
					st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	assign par_index_out    = idx_q;
	assign par_eeprom_out   = pwc_q;
	assign preset_ref_out   = ctl_q[`MB_CTL_PRESET +: 2];
	assign dc_brake_n_out   = ctl_q[`MB_CTL_DCBRAKE_N];
	assign coast_n_out      = ctl_q[`MB_CTL_COAST_N];
	assign quick_stop_n_out = ctl_q[`MB_CTL_QSTOP_N];
	assign freeze_n_out     = ctl_q[`MB_CTL_FREEZE_N];
	assign start_out        = ctl_q[`MB_CTL_START];
	assign fault_reset_out  = ctl_q[`MB_CTL_RESET];
	assign jog_out          = ctl_q[`MB_CTL_JOG];
	assign ramp2_out        = ctl_q[`MB_CTL_RAMP2];
	assign data_valid_out   = ctl_q[`MB_CTL_DVALID];
	assign relay1_out       = ctl_q[`MB_CTL_RELAY1];
	assign relay2_out       = ctl_q[`MB_CTL_RELAY2];
	assign setup_sel_out    = ctl_q[`MB_CTL_SETUP +: 2];
	assign reverse_out      = ctl_q[`MB_CTL_REVERSE];
	assign speed_ref_out    = ref_q;
endmodule : mb_data_map
`default_nettype wire

// ---- mb_data_map_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module mb_data_map_assertions (
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        req_valid_in,
	input wire logic [7:0]  req_func_in,
	input wire logic [15:0] req_addr_in,
	input wire logic [15:0] req_qty_in,
	input wire logic        busy_out,
	input wire logic        rsp_done_out,
	input wire logic [7:0]  rsp_func_out,
	input wire logic [7:0]  rsp_exc_out,
	input wire logic        comm_restart_out,
	input wire logic        par_req_out,
	input wire logic        par_ack_in,
	input wire logic        par_eeprom_out,
	input wire logic        start_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_take(f, a, q);
		req_valid_in && !busy_out && req_func_in == f && req_addr_in == a && req_qty_in == q;
	endsequence
	sequence s_exc(c);
		rsp_done_out && rsp_exc_out == c;
	endsequence
	a_exc_flag: assert property (rsp_done_out && rsp_exc_out != 8'h00 |-> rsp_func_out[7])
		else $error("flag missing");
	a_ok_echo: assert property (s_exc(8'h00) |-> !rsp_func_out[7])
		else $error("flag on success");
	a_bad_func: assert property (s_take(8'h02, 16'h0000, 16'h0001) |-> ##3 s_exc(8'h43) ##0 rsp_func_out == 8'h82)
		else $error("bad function answer");
	a_reserved: assert property (s_take(8'h03, 16'h0000, 16'h0001) |-> ##3 s_exc(8'h40))
		else $error("reserved accepted");
	a_pwc_on: assert property (s_take(8'h05, 16'h0040, 16'hFF00) |-> ##[1:5] par_eeprom_out)
		else $error("storage coil not set");
	a_start_on: assert property (s_take(8'h05, 16'h0006, 16'hFF00) |-> ##[1:5] start_out)
		else $error("start not set");
	a_restart: assert property (s_take(8'h08, 16'h0001, 16'h0000) |-> ##[1:5] comm_restart_out)
		else $error("no restart");
	a_par_hold: assert property (par_req_out && !par_ack_in |=> par_req_out)
		else $error("request dropped");
endmodule : mb_data_map_assertions
bind mb_data_map mb_data_map_assertions i_mb_data_map_assertions (.clk_in, .rst_in, .req_valid_in, .req_func_in,
	.req_addr_in, .req_qty_in, .busy_out, .rsp_done_out, .rsp_func_out, .rsp_exc_out, .comm_restart_out,
	.par_req_out, .par_ack_in, .par_eeprom_out, .start_out);
`default_nettype wire

// ---- mb_par_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module mb_par_model (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        req_in,
	input  wire logic        we_in,
	input  wire logic        fail_in,
	input  wire logic [15:0] num_in,
	input  wire logic [15:0] wd_in,
	output logic             ack_out,
	output logic             fail_out,
	output logic      [15:0] rd_out
);
	logic [15:0] mem_q [256];
	logic [1:0]  dly_q;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_out <= 1'b0;
			fail_out <= 1'b0;
			dly_q <= 2'h0;
			rd_out <= 16'h0000;
		end else begin
			ack_out <= 1'b0;
			rd_out <= ~rd_out;
			if (req_in && !ack_out) begin
				dly_q <= dly_q + 2'h1;
				if (dly_q == 2'h3) begin
					ack_out <= 1'b1;
					fail_out <= fail_in;
					rd_out <= mem_q[num_in[7:0]];
					if (we_in && !fail_in)
						mem_q[num_in[7:0]] <= wd_in;
				end
			end
		end
	end
endmodule : mb_par_model
`default_nettype wire

// ---- mb_data_map_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module mb_data_map_tb;
	logic        clk_in = 1'b0, rst_in = 1'b1, req_valid_in = 1'b0, wd_valid_in = 1'b0, bus_msg_in = 1'b0;
	logic        comm_err_in = 1'b0, pfail = 1'b0, ack, fl, busy_out, rsp_item_valid_out, rsp_done_out, preq, pwe;
	logic        par_eeprom_out, start_out, coast_n_out, reverse_out;
	logic        dc_brake_n_out, quick_stop_n_out, freeze_n_out, fault_reset_out, jog_out, ramp2_out;
	logic        data_valid_out, relay1_out, relay2_out, comm_restart_out;
	logic [1:0]  preset_ref_out, setup_sel_out;
	logic [7:0]  req_func_in = 8'h00, rfunc, rexc;
	logic [15:0] req_addr_in = 16'h0000, req_qty_in = 16'h0000, wd_data_in = 16'h0000, rdat, regn, wdat;
	logic [15:0] status_word_in = 16'h0607, actual_value_in = 16'h1357, rsp_item_out, par_index_out, speed_ref_out;
	logic [15:0] items [$];
	int          fail_count = 0, checks = 0, restarts = 0;
	always #50 clk_in = ~clk_in;
	mb_data_map i_mb_data_map (.clk_in, .rst_in, .req_valid_in, .req_bcast_in(1'b0), .req_func_in, .req_addr_in,
		.req_qty_in, .wd_valid_in, .wd_data_in, .bus_msg_in, .comm_err_in, .status_word_in, .actual_value_in,
		.par_ack_in(ack), .par_fail_in(fl), .par_rdata_in(rdat), .par_errcode_in(8'h12), .busy_out,
		.wd_ready_out(), .rsp_item_valid_out, .rsp_item_out, .rsp_done_out, .rsp_func_out(rfunc),
		.rsp_exc_out(rexc), .comm_restart_out, .par_req_out(preq), .par_we_out(pwe), .par_regnum_out(regn),
		.par_wdata_out(wdat), .par_index_out, .par_eeprom_out, .preset_ref_out, .dc_brake_n_out,
		.coast_n_out, .quick_stop_n_out, .freeze_n_out, .start_out, .fault_reset_out, .jog_out,
		.ramp2_out, .data_valid_out, .relay1_out, .relay2_out, .setup_sel_out, .reverse_out,
		.speed_ref_out);
	mb_par_model i_mb_par_model (.clk_in, .rst_in, .req_in(preq), .we_in(pwe), .fail_in(pfail), .num_in(regn),
		.wd_in(wdat), .ack_out(ack), .fail_out(fl), .rd_out(rdat));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q);
		int n;
		n = 0;
		items.delete();
		@(posedge clk_in);
		req_valid_in <= 1'b1;
		req_func_in <= f;
		req_addr_in <= a;
		req_qty_in <= q;
		@(posedge clk_in);
		req_valid_in <= 1'b0;
		wd_valid_in <= 1'b1;
		do begin
			@(posedge clk_in);
			#1;
			if (rsp_item_valid_out === 1'b1)
				items.push_back(rsp_item_out);
			if (comm_restart_out === 1'b1)
				restarts++;
			n++;
		end while (rsp_done_out !== 1'b1 && n < 300);
		if (n >= 300)
			fail_count++;
		@(posedge clk_in);
		wd_valid_in <= 1'b0;
	endtask : req
	task automatic t_coils;
		req(8'h05, 16'h0040, 16'hFF00);
		chk(items[0], 16'h0040);
		chk(items[1], 16'hFF00);
		chk({15'h0000, par_eeprom_out}, 16'h0001);
		req(8'h05, 16'h0040, 16'h0000);
		chk({15'h0000, par_eeprom_out}, 16'h0000);
		req(8'h05, 16'h0006, 16'hFF00);
		wd_data_in <= 16'h8041;
		req(8'h0F, 16'h0000, 16'h0010);
		chk({12'h000, reverse_out, start_out, preset_ref_out}, 16'h000D);
	endtask : t_coils
	task automatic t_regs;
		req(8'h06, 16'hC359, 16'hA5C3);
		chk(speed_ref_out, 16'hA5C3);
		wd_data_in <= 16'h0008;
		req(8'h10, 16'hC34F, 16'h0001);
		chk({15'h0000, coast_n_out}, 16'h0001);
		wd_data_in <= 16'h5AA5;
		req(8'h10, 16'hC34F, 16'h0001);
		chk({reverse_out, setup_sel_out, relay2_out, relay1_out, data_valid_out, ramp2_out, jog_out,
			fault_reset_out, start_out, freeze_n_out, quick_stop_n_out, coast_n_out, dc_brake_n_out,
			preset_ref_out}, 16'h5AA5);
		req(8'h03, 16'hC417, 16'h0001);
		chk(items[0], 16'h0607);
		req(8'h03, 16'hC421, 16'h0001);
		chk(items[0], 16'h1357);
		req(8'h01, 16'h0020, 16'h0008);
		chk({8'h00, items[0][7:0]}, 16'h0007);
	endtask : t_regs
	task automatic t_params;
		req(8'h06, 16'h0008, 16'h0003);
		chk(par_index_out, 16'h0003);
		req(8'h06, 16'h03E7, 16'h0055);
		chk(regn, 16'h03E8);
		req(8'h03, 16'h03E7, 16'h0001);
		chk(items[0], 16'h0055);
		pfail <= 1'b1;
		req(8'h03, 16'h03E7, 16'h0001);
		pfail <= 1'b0;
		req(8'h03, 16'h0006, 16'h0001);
		chk(items[0], 16'h0012);
	endtask : t_params
	task automatic t_errors;
		req(8'h02, 16'h0000, 16'h0001);
		chk({rfunc, rexc}, 16'h8243);
		req(8'h03, 16'h0000, 16'h0001);
		chk({rfunc, rexc}, 16'h8340);
		req(8'h05, 16'h0020, 16'hFF00);
		chk({rfunc, rexc}, 16'h8540);
		req(8'h05, 16'h0006, 16'h1234);
		chk({rfunc, rexc}, 16'h8542);
	endtask : t_errors
	task automatic t_diag;
		req(8'h08, 16'h000A, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in);
			bus_msg_in <= 1'b1;
			comm_err_in <= (i == 0);
			@(posedge clk_in);
			bus_msg_in <= 1'b0;
			comm_err_in <= 1'b0;
		end
		req(8'h08, 16'h000B, 16'h0000);
		chk(items[1], 16'h0004);
		req(8'h08, 16'h000C, 16'h0000);
		chk(items[1], 16'h0001);
		req(8'h02, 16'h0000, 16'h0001);
		req(8'h08, 16'h000D, 16'h0000);
		chk(items[1], 16'h0001);
		req(8'h08, 16'h0002, 16'h0000);
		chk(items[1], 16'h0043);
		req(8'h08, 16'h0001, 16'h0000);
		req(8'h11, 16'h0000, 16'h0000);
		chk(items[0], 16'h005A);
		req(8'h0B, 16'h0000, 16'h0000);
		chk(items[1], 16'h0002);
		chk({rfunc, rexc}, 16'h0B00);
		req(8'h08, 16'h000E, 16'h0000);
		chk(items[1], 16'h0003);
		chk(16'(restarts), 16'h0001);
	endtask : t_diag
	task automatic finish_test;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	initial begin
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		chk(speed_ref_out, 16'h0000);
		t_coils;
		t_regs;
		t_params;
		t_errors;
		t_diag;
		finish_test;
	end
	initial begin
		#2000000;
		fail_count++;
		finish_test;
	end
endmodule : mb_data_map_tb
`default_nettype wire
